// ---- logic/mfw_pkg.sv ----
// Package with register map, constants and carrier types of the frame exception and wake block.
package mfw_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MAIN = 8'h00;
  localparam logic [7:0] OFS_FEAT = 8'h04;
  localparam logic [7:0] OFS_PWR = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_FTH = 8'h10;
  localparam logic [7:0] OFS_TEST = 8'h14;
  localparam logic [7:0] OFS_ADRL = 8'h18;
  localparam logic [7:0] OFS_ADRH = 8'h1c;
  localparam logic [7:0] OFS_TXST = 8'h20;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_COLLISION_ERROR_BIT = 0;
  localparam int B_ERR = 1;
  localparam int B_GLOBAL_INTERRUPT_ENABLE = 6;
  localparam int B_PADSTRIP = 10;
  localparam int B_PERMIT = 1;
  localparam int B_SWWAKE = 2;
  localparam int B_WAKEIE = 3;
  localparam int B_WAKERX = 4;
  localparam int B_SUSP = 5;
  localparam int B_ACCEPT_ALL_FRAMES = 0;
  localparam int B_BCDIS = 1;
  localparam int B_TPSEL = 2;
  localparam int B_RPA = 0;
  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [1:0] RECEIVE_FIFO_WATERMARK_RST = 2'h2;
  localparam logic [9:0] SLOT_BITS = 10'h200;
  localparam logic [5:0] SQE_BITS = 6'h28;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [15:0] PAD_MIN_LEN = 16'h002e;
  localparam logic [10:0] HDR_BYTES = 11'h00e;
  localparam logic [4:0] WAKE_REPEATS = 5'h10;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } mfw_byte_t;
  typedef struct packed {
    logic done;
    logic retry;
    logic carrierLost;
    logic lateCol;
  } mfw_txstat_t;
  typedef struct packed {
    logic commit;
    logic discard;
    logic crcErr;
  } mfw_rxend_t;
  typedef enum logic [1:0] {
    PW_NORMAL = 2'b00,
    PW_DRAIN = 2'b01,
    PW_SUSP = 2'b10
  } mfw_pw_t;
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic global_interrupt_enable;
    logic collision_error_bit;
    logic err;
    logic padStrip;
    logic permit;
    logic swWake;
    logic wakeIe;
    logic wakeRx;
    logic accept_all_frames;
    logic bcDis;
    logic tpSel;
    logic [1:0] receive_fifo_watermark;
    logic runt_accept_enable;
    logic [47:0] sta;
    logic txBusy;
    logic seen;
    logic drop;
    logic tpFault;
    logic [9:0] slotCnt;
    logic sqeOn;
    logic [5:0] sqeCnt;
    mfw_txstat_t txSt;
    logic lastLcar;
    logic lastLcol;
    logic rxBusy;
    logic [10:0] rxCnt;
    logic [7:0] lenHi;
    logic strip;
    logic [10:0] keep;
    logic match;
    logic bcast;
    logic rxCol;
    logic [31:0] crc;
    mfw_byte_t rxOut;
    mfw_rxend_t rxEnd;
    mfw_pw_t pw;
    logic susp;
    logic flush;
    logic [2:0] wIdx;
    logic [4:0] wRep;
    logic interrupt_output;
  } mfw_state_t;
endpackage : mfw_pkg

// ---- logic/mfw_core.sv ----
// Frame exception handling, receive filtering and wake-frame suspend of a 10 Mb/s MAC.
// Notes on behaviour
// - On AUI, missing or dropped looped-back carrier sets carrier-lost after the frame.
// - A carrier-lost frame is never retried for that reason.
// - On twisted pair, jabber or link fail during transmit sets carrier-lost.
// - Collision after 512 bit times abandons the frame, flags late collision, no retry.
// - On AUI, no collision pair within 40 bit times after transmit sets collision error.
// - On twisted pair, link fail after transmit sets collision error.
// - Collision error never drives interrupt but sets the summary error bit.
// - Accept-all takes every frame meeting minimum length, overriding broadcast disable.
// - Receive FIFO watermark resets to 10b, a threshold of 64 bytes.
// - Pad-strip enable, bit 10, removes pad and checksum before the FIFO.
// - Length below 46 strips pad; length or type of 46 or more passes unmodified.
// - Checksum is checked over all received bytes and reported even when stripped.
// - Frames colliding within 512 bit times of start are deleted silently.
// - Frames under 64 bytes are discarded unless runt accept is enabled.
// - Suspend waits for transfers to finish, then flushes the receive FIFO.
// - Wake frame holds the station address sixteen times in a row, LSB first.
// - Sleep input low enters suspend; its release returns to normal operation.
// - Software wake enable, bit 2, enters suspend; clearing it leaves.
// - A wake frame sets the wake-received flag, bit 4, and the indicator output.
// - Wake interrupt needs both wake interrupt enable and global interrupt enable.
//
// Decided for this implementation: register access over APB and the register addresses.
module mfw_core import mfw_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Network pins, asynchronous.
  input wire logic rxCarrier,
  input wire logic collisionPair,
  input wire logic linkFail,
  input wire logic jabber,
  input wire logic sleepReq_n,
  // Transmit engine.
  input wire logic txStart,
  input wire logic txEnd,
  input wire logic txBitTick,
  output mfw_txstat_t txStatus,
  // Receive byte stream and FIFO side.
  input mfw_byte_t rxIn,
  output mfw_byte_t rxFifo,
  output mfw_rxend_t rxFrameEnd,
  output logic [1:0] receiveFifoWatermark,
  output logic fifoFlush,
  // Power and indication.
  output logic suspended,
  output logic wakeIndicator,
  output logic interruptOutput
);
  // ----------------------------------------
  // State and combinational temporaries
  // ----------------------------------------
  mfw_state_t s;
  mfw_state_t n;
  logic crs, col, lf, jab, slp;
  logic wr, wMain, wPwr;
  logic cerrSet, wakeSet, req, bad;
  logic [10:0] idx;
  logic [15:0] len;
  logic [31:0] crcV;

  // Synchronised pins.
  assign crs = s.sync2[0];
  assign col = s.sync2[1];
  assign lf = s.sync2[2];
  assign jab = s.sync2[3];
  assign slp = s.sync2[4];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Computes the whole next state from the current state and inputs.
  always_comb begin
    n = s;
    cerrSet = 1'b0;
    wakeSet = 1'b0;
    bad = 1'b0;
    len = 16'h0000;
    idx = s.rxCnt;
    crcV = s.crc;
    n.sync1 = {~sleepReq_n, jabber, linkFail, collisionPair, rxCarrier};
    n.sync2 = s.sync1;
    n.txSt = '0;
    n.rxOut = '0;
    n.rxEnd = '0;
    n.flush = 1'b0;
    // Bus: answer in the first access cycle, data prepared in setup.
    wr = psel & penable & s.pready & pwrite;
    wMain = wr && paddr == OFS_MAIN;
    wPwr = wr && paddr == OFS_PWR;
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_MAIN: begin
          n.prdata[B_COLLISION_ERROR_BIT] = s.collision_error_bit;
          n.prdata[B_ERR] = s.err;
          n.prdata[B_GLOBAL_INTERRUPT_ENABLE] = s.global_interrupt_enable;
        end
        OFS_FEAT: n.prdata[B_PADSTRIP] = s.padStrip;
        OFS_PWR: begin
          n.prdata[B_PERMIT] = s.permit;
          n.prdata[B_SWWAKE] = s.swWake;
          n.prdata[B_WAKEIE] = s.wakeIe;
          n.prdata[B_WAKERX] = s.wakeRx;
          n.prdata[B_SUSP] = s.susp;
        end
        OFS_MODE: begin
          n.prdata[B_ACCEPT_ALL_FRAMES] = s.accept_all_frames;
          n.prdata[B_BCDIS] = s.bcDis;
          n.prdata[B_TPSEL] = s.tpSel;
        end
        OFS_FTH: n.prdata[1:0] = s.receive_fifo_watermark;
        OFS_TEST: n.prdata[B_RPA] = s.runt_accept_enable;
        OFS_ADRL: n.prdata = s.sta[31:0];
        OFS_ADRH: n.prdata[15:0] = s.sta[47:32];
        OFS_TXST: n.prdata[1:0] = {s.lastLcol, s.lastLcar};
        default: n.pslverr = 1'b1;
      endcase
    end
    // Register writes; status bits clear by writing one.
    if (wMain) begin
      n.global_interrupt_enable = pwdata[B_GLOBAL_INTERRUPT_ENABLE];
      n.collision_error_bit = s.collision_error_bit & ~pwdata[B_COLLISION_ERROR_BIT];
      n.err = s.err & ~pwdata[B_ERR];
    end
    if (wr && paddr == OFS_FEAT) n.padStrip = pwdata[B_PADSTRIP];
    if (wPwr) begin
      n.permit = pwdata[B_PERMIT];
      n.swWake = pwdata[B_SWWAKE];
      n.wakeIe = pwdata[B_WAKEIE];
      n.wakeRx = s.wakeRx & ~pwdata[B_WAKERX];
    end
    if (wr && paddr == OFS_MODE) begin
      n.accept_all_frames = pwdata[B_ACCEPT_ALL_FRAMES];
      n.bcDis = pwdata[B_BCDIS];
      n.tpSel = pwdata[B_TPSEL];
    end
    if (wr && paddr == OFS_FTH) n.receive_fifo_watermark = pwdata[1:0];
    if (wr && paddr == OFS_TEST) n.runt_accept_enable = pwdata[B_RPA];
    if (wr && paddr == OFS_ADRL) n.sta[31:0] = pwdata;
    if (wr && paddr == OFS_ADRH) n.sta[47:32] = pwdata[15:0];

    // Collision-error test window after a transmit on the AUI port.
    if (s.sqeOn) begin
      if (col) begin
        n.sqeOn = 1'b0;
      end else if (txBitTick) begin
        n.sqeCnt = s.sqeCnt + 6'h01;
        if (s.sqeCnt == SQE_BITS - 6'h01) begin
          n.sqeOn = 1'b0;
          cerrSet = 1'b1;
        end
      end
    end
    // Transmit attempt supervision.
    if (s.txBusy) begin
      if (txBitTick && s.slotCnt != SLOT_BITS) n.slotCnt = s.slotCnt + 10'h001;
      if (crs) n.seen = 1'b1;
      if (s.seen && !crs) n.drop = 1'b1;
      if (lf || jab) n.tpFault = 1'b1;
      if (col && s.slotCnt == SLOT_BITS) begin
        n.txBusy = 1'b0;
        n.txSt = '{done: 1'b1, retry: 1'b0, carrierLost: 1'b0, lateCol: 1'b1};
        n.lastLcol = 1'b1;
        n.lastLcar = 1'b0;
      end else if (col && !s.tpSel) begin
        n.txBusy = 1'b0;
        n.txSt.done = 1'b1;
        n.txSt.retry = 1'b1;
      end else if (txEnd) begin
        n.txBusy = 1'b0;
        n.txSt.done = 1'b1;
        n.txSt.carrierLost = s.tpSel ? (s.tpFault | lf | jab) : (~(s.seen | crs) | s.drop);
        n.txSt.retry = 1'b0;
        n.lastLcar = n.txSt.carrierLost;
        n.lastLcol = 1'b0;
        n.sqeOn = ~s.tpSel;
        n.sqeCnt = 6'h00;
        if (s.tpSel && lf) cerrSet = 1'b1;
      end
    end else if (txStart && s.pw == PW_NORMAL) begin
      n.txBusy = 1'b1;
      n.slotCnt = 10'h000;
      n.seen = 1'b0;
      n.drop = 1'b0;
      n.tpFault = 1'b0;
      n.sqeOn = 1'b0;
    end

    // Receive path, active outside suspend.
    if (s.rxBusy && col && s.rxCnt < MIN_FRAME) n.rxCol = 1'b1;
    if (rxIn.valid && s.pw != PW_SUSP && (s.rxBusy || (rxIn.sof && s.pw == PW_NORMAL))) begin
      if (rxIn.sof) begin
        idx = 11'h000;
        crcV = 32'hffff_ffff;
        n.match = 1'b1;
        n.bcast = 1'b1;
        n.strip = 1'b0;
        n.rxCol = col;
      end
      n.rxBusy = 1'b1;
      crcV = crcV ^ {24'h000000, rxIn.data};
      for (int b = 0; b < 8; b++) begin
        crcV = crcV[0] ? ((crcV >> 1) ^ CRC_POLY) : (crcV >> 1);
      end
      n.crc = crcV;
      if (idx < 11'h006) begin
        if (rxIn.data != s.sta[8 * idx[2:0] +: 8]) n.match = 1'b0;
        if (rxIn.data != 8'hff) n.bcast = 1'b0;
      end
      if (idx == 11'h00c) n.lenHi = rxIn.data;
      if (idx == 11'h00d) begin
        len = {s.lenHi, rxIn.data};
        n.strip = s.padStrip && len < PAD_MIN_LEN;
        n.keep = HDR_BYTES + len[10:0];
      end
      n.rxOut.valid = ~s.strip | (idx < s.keep);
      n.rxOut.sof = rxIn.sof;
      n.rxOut.data = rxIn.data;
      if (idx != 11'h7ff) n.rxCnt = idx + 11'h001;
      if (rxIn.eof) begin
        bad = (idx + 11'h001 < MIN_FRAME && !s.runt_accept_enable) || n.rxCol;
        bad = bad || !(s.accept_all_frames || n.match || (n.bcast && !s.bcDis));
        n.rxBusy = 1'b0;
        n.rxOut.eof = 1'b1;
        n.rxEnd.commit = ~bad;
        n.rxEnd.discard = bad;
        n.rxEnd.crcErr = ~bad & (crcV != CRC_RESIDUE);
      end
    end

    // Wake-frame matcher, active only in suspend.
    if (rxIn.valid && s.pw == PW_SUSP) begin
      n.wIdx = rxIn.sof ? 3'h0 : s.wIdx;
      n.wRep = rxIn.sof ? 5'h00 : s.wRep;
      if (rxIn.data == s.sta[8 * n.wIdx +: 8]) begin
        if (n.wIdx == 3'h5) begin
          n.wIdx = 3'h0;
          if (n.wRep == WAKE_REPEATS - 5'h01) wakeSet = 1'b1;
          if (n.wRep != WAKE_REPEATS) n.wRep = n.wRep + 5'h01;
        end else begin
          n.wIdx = n.wIdx + 3'h1;
        end
      end else begin
        n.wIdx = {2'b00, rxIn.data == s.sta[7:0]};
        n.wRep = 5'h00;
      end
    end

    // Suspend control from the sleep pin or the software bit.
    req = s.permit & (s.swWake | slp);
    unique case (s.pw)
      PW_NORMAL: if (req) n.pw = PW_DRAIN;
      PW_DRAIN: begin
        if (!req) begin
          n.pw = PW_NORMAL;
        end else if (!s.txBusy && !s.rxBusy) begin
          n.pw = PW_SUSP;
          n.flush = 1'b1;
          n.wIdx = 3'h0;
          n.wRep = 5'h00;
        end
      end
      PW_SUSP: if (!req) n.pw = PW_NORMAL;
      default: n.pw = PW_NORMAL;
    endcase
    n.susp = n.pw == PW_SUSP;

    // Sticky flags: the hardware set wins over a clear in the same cycle.
    n.collision_error_bit = n.collision_error_bit | cerrSet;
    n.err = n.err | cerrSet;
    n.wakeRx = n.wakeRx | wakeSet;
    n.interrupt_output = n.wakeRx & n.wakeIe & n.global_interrupt_enable;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Registers the whole state; reset gives constants only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.receive_fifo_watermark <= RECEIVE_FIFO_WATERMARK_RST;
      s.pw <= PW_NORMAL;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txStatus = s.txSt;
  assign rxFifo = s.rxOut;
  assign rxFrameEnd = s.rxEnd;
  assign receiveFifoWatermark = s.receive_fifo_watermark;
  assign fifoFlush = s.flush;
  assign suspended = s.susp;
  assign wakeIndicator = s.wakeRx;
  assign interruptOutput = s.interrupt_output;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence sAuiEndNoCarrier;
    s.txBusy && !s.tpSel && txEnd && !col && !s.seen && !crs;
  endsequence
  sequence sDrainIdle;
    s.pw == PW_DRAIN && !s.txBusy && !s.rxBusy && s.permit && (s.swWake || slp);
  endsequence

  chk_carrier_lost_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    sAuiEndNoCarrier |=> txStatus.done && txStatus.carrierLost)
    else $error("carrier loss not flagged");
  chk_carrier_lost_flag_noretry: assert property (@(posedge clk) disable iff (!arst_n)
    txStatus.carrierLost |-> !txStatus.retry)
    else $error("carrier loss caused retry");
  chk_late_col: assert property (@(posedge clk) disable iff (!arst_n)
    txStatus.lateCol |-> $past(s.slotCnt) == SLOT_BITS && !txStatus.retry)
    else $error("late collision flagged early or retried");
  chk_sqe_window: assert property (@(posedge clk) disable iff (!arst_n)
    s.sqeOn && txBitTick && !col && s.sqeCnt == SQE_BITS - 6'h01 |=> s.collision_error_bit && s.err)
    else $error("collision error missed");
  chk_collision_error_bit_noint: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(interruptOutput) |-> $past(s.wakeRx || wakeSet) && s.wakeIe && s.global_interrupt_enable)
    else $error("interrupt without wake cause");
  chk_runt_drop: assert property (@(posedge clk) disable iff (!arst_n)
    rxFrameEnd.commit && !$past(s.runt_accept_enable) |-> $past(idx) >= MIN_FRAME - 11'h001)
    else $error("runt frame committed");
  chk_wake_int: assert property (@(posedge clk) disable iff (!arst_n)
    !wPwr && !wMain && s.wakeRx && s.wakeIe && s.global_interrupt_enable |=> interruptOutput)
    else $error("wake interrupt missing");
  chk_suspend_entry: assert property (@(posedge clk) disable iff (!arst_n)
    sDrainIdle |=> suspended && fifoFlush ##1 !fifoFlush)
    else $error("suspend entry wrong");
  chk_wake_leave: assert property (@(posedge clk) disable iff (!arst_n)
    suspended && !s.swWake && !slp |=> !suspended)
    else $error("suspend not left");
endmodule : mfw_core

// ---- verification/mfw_net_model.sv ----
// Behavioural model of the network transceiver facing the frame exception and wake block.
module mfw_net_model import mfw_pkg::*; (
  // Clock, reset and transmit activity seen on the pair.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic txStart,
  input wire logic txEnd,
  // Pins towards the block.
  output logic rxCarrier,
  output logic collisionPair,
  output logic linkFail,
  output logic jabber,
  output mfw_byte_t rxIn
);
  logic loopOn = 1'b1;
  logic sqeOn = 1'b1;
  logic txOn;
  logic [5:0] sqeCnt;
  logic [3:0] colCnt = 4'h0;
  // Quiet line until the bench asks for anything.
  initial begin
    linkFail = 1'b0;
    jabber = 1'b0;
    rxIn = '0;
  end
  // Sets loopback, self-test echo and the transceiver fault levels.
  task cfg(input logic lp, input logic sq, input logic lf, input logic jb);
    loopOn <= lp;
    sqeOn <= sq;
    linkFail <= lf;
    jabber <= jb;
  endtask : cfg
  // Starts an eight-cycle burst on the collision pair.
  task collide();
    colCnt <= 4'h8;
  endtask : collide
  // Sends one frame byte by byte; the idle data afterwards is the inverse of the last byte.
  task sendFrame(input logic [7:0] q[$], input int colAt);
    for (int i = 0; i < q.size(); i++) begin
      rxIn <= '{1'b1, i == 0, i == q.size() - 1, q[i]};
      if (i == colAt) colCnt <= 4'h8;
      @(posedge clk);
    end
    rxIn <= '{1'b0, 1'b0, 1'b0, ~q[q.size() - 1]};
  endtask : sendFrame
  // Loops carrier back while sending and echoes the self-test burst ten bit times after the frame.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txOn <= 1'b0;
      sqeCnt <= 6'h0;
      rxCarrier <= 1'b0;
      collisionPair <= 1'b0;
    end else begin
      if (txStart) txOn <= 1'b1;
      if (txEnd) txOn <= 1'b0;
      sqeCnt <= (txEnd && sqeOn) ? 6'h1 : ((sqeCnt != 6'h0) ? sqeCnt + 6'h1 : sqeCnt);
      if (colCnt != 4'h0) colCnt <= colCnt - 4'h1;
      rxCarrier <= loopOn && txOn;
      collisionPair <= (colCnt != 4'h0) || (sqeCnt >= 6'h14 && sqeCnt < 6'h1e);
    end
  end
endmodule : mfw_net_model

// ---- verification/test_mfw_core.sv ----
// Self-checking bench for the frame exception and wake block.
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failCount++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module test_mfw_core import mfw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleepReq_n = 1'b1;
  logic txStart = 1'b0, txEnd = 1'b0, txBitTick = 1'b0, errS, gotEnd, flushSeen = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, crc;
  logic pready, pslverr, rxCarrier, collisionPair, linkFail, jabber;
  logic fifoFlush, suspended, wakeIndicator, interruptOutput;
  logic [1:0] receiveFifoWatermark;
  mfw_txstat_t txStatus, ts;
  mfw_byte_t rxIn, rxFifo;
  mfw_rxend_t rxFrameEnd, lastEnd;
  logic [7:0] fr[$], pl[$];
  int failCount = 0, cmpCount = 0, outCnt = 0, cyc = 0;
  mfw_core i_mfw_core (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxCarrier(rxCarrier), .collisionPair(collisionPair), .linkFail(linkFail), .jabber(jabber),
    .sleepReq_n(sleepReq_n), .txStart(txStart), .txEnd(txEnd), .txBitTick(txBitTick),
    .txStatus(txStatus), .rxIn(rxIn), .rxFifo(rxFifo), .rxFrameEnd(rxFrameEnd),
    .receiveFifoWatermark(receiveFifoWatermark), .fifoFlush(fifoFlush), .suspended(suspended),
    .wakeIndicator(wakeIndicator), .interruptOutput(interruptOutput));
  mfw_net_model i_mfw_net_model (.clk(clk), .arst_n(arst_n), .txStart(txStart), .txEnd(txEnd),
    .rxCarrier(rxCarrier), .collisionPair(collisionPair), .linkFail(linkFail), .jabber(jabber), .rxIn(rxIn));
  // Clock of 10 ns period.
  initial forever #5 clk = ~clk;
  // Transmit bit tick every second cycle, and a cycle ceiling against hangs.
  always @(posedge clk) begin
    txBitTick <= arst_n && !txBitTick;
    cyc++;
    if (cyc == 40000) begin
      failCount++;
      stopTest();
    end
  end
  // Counts bytes entering the FIFO and keeps the frame end and flush events, sampled mid-cycle.
  always @(negedge clk) begin
    if (rxFifo.valid === 1'b1) outCnt++;
    if (rxFifo.eof === 1'b1) begin
      lastEnd = rxFrameEnd;
      gotEnd = 1'b1;
    end
    if (fifoFlush === 1'b1) flushSeen = 1'b1;
  end
  // Prints the counts and the verdict, then ends the run.
  task stopTest();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stopTest
  // One APB transfer; the request stands until the rising edge that samples pready high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    errS = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // One transmit attempt of len cycles ending in txEnd or a collision; keeps the status pulse.
  task txRun(input int len, input logic col);
    txStart <= 1'b1;
    @(posedge clk);
    txStart <= 1'b0;
    repeat (len) @(posedge clk);
    if (col) i_mfw_net_model.collide();
    else txEnd <= 1'b1;
    @(posedge clk);
    txEnd <= 1'b0;
    repeat (20) begin
      @(negedge clk);
      if (txStatus.done === 1'b1) break;
    end
    ts = txStatus;
    @(posedge clk);
  endtask : txRun
  // Builds a broadcast frame with payload pl, zero pad up to total bytes and a valid checksum.
  task build(input logic [15:0] lenf, input int total);
    fr = {};
    repeat (6) fr.push_back(8'hff);
    for (int i = 0; i < 6; i++) fr.push_back(8'(i + 2));
    fr.push_back(lenf[15:8]);
    fr.push_back(lenf[7:0]);
    fr = {fr, pl};
    while (fr.size() < total - 4) fr.push_back(8'h00);
    crc = 32'hffffffff;
    foreach (fr[i]) begin
      crc ^= {24'h0, fr[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
    end
    for (int i = 0; i < 4; i++) fr.push_back(~crc[8 * i +: 8]);
  endtask : build
  // Sends fr and judges the frame end {commit, discard, crcErr} and, if n is not negative, the byte count.
  task rxRun(input int colAt, input int n, input logic [2:0] e);
    outCnt = 0;
    gotEnd = 1'b0;
    i_mfw_net_model.sendFrame(fr, colAt);
    repeat (4) @(posedge clk);
    `CHK({gotEnd, lastEnd}, {1'b1, e})
    if (n >= 0) `CHK(outCnt, n)
    repeat (20) @(posedge clk);
  endtask : rxRun
  // Sends a frame holding n copies of the station address after a sync run.
  task wakeFrame(input int n);
    pl = {};
    repeat (6) pl.push_back(8'hff);
    repeat (n) for (int i = 0; i < 6; i++) pl.push_back(8'(17 * (i + 1)));
    build(16'h0800, 124);
    i_mfw_net_model.sendFrame(fr, -1);
    repeat (6) @(posedge clk);
  endtask : wakeFrame
  // Waits a bounded time for the suspended output to reach v.
  task waitSusp(input logic v);
    repeat (300) begin
      @(negedge clk);
      if (suspended === v) break;
    end
    @(posedge clk);
    `CHK(suspended, v)
  endtask : waitSusp
  // Reset values, watermark field and an unmapped access.
  task testRegs();
    `CHK(receiveFifoWatermark, 2'b10)
    apb(1'b0, OFS_FTH, 32'h0);
    `CHK(rd[1:0], 2'b10)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({errS, rd}, {1'b1, 32'h0})
    apb(1'b1, OFS_FTH, 32'h1);
    `CHK(receiveFifoWatermark, 2'b01)
    $display("register test done");
  endtask : testRegs
  // Carrier loss, self-test error, late and early collision on the AUI port.
  task testTx();
    apb(1'b1, OFS_MAIN, 32'h40);
    i_mfw_net_model.cfg(1'b0, 1'b1, 1'b0, 1'b0);
    txRun(200, 1'b0);
    `CHK({ts.done, ts.retry, ts.carrierLost}, 3'b101)
    apb(1'b0, OFS_TXST, 32'h0);
    `CHK(rd[0], 1'b1)
    i_mfw_net_model.cfg(1'b1, 1'b1, 1'b0, 1'b0);
    txRun(200, 1'b0);
    repeat (100) @(posedge clk);
    apb(1'b0, OFS_MAIN, 32'h0);
    `CHK({ts.carrierLost, rd[1:0]}, 3'b000)
    i_mfw_net_model.cfg(1'b1, 1'b0, 1'b0, 1'b0);
    txRun(200, 1'b0);
    repeat (100) @(posedge clk);
    apb(1'b0, OFS_MAIN, 32'h0);
    `CHK({interruptOutput, rd[1:0]}, 3'b011)
    apb(1'b1, OFS_MAIN, 32'h43);
    i_mfw_net_model.cfg(1'b1, 1'b1, 1'b0, 1'b0);
    txRun(1100, 1'b1);
    `CHK({ts.done, ts.retry, ts.lateCol}, 3'b101)
    repeat (40) @(posedge clk);
    txRun(100, 1'b1);
    `CHK({ts.done, ts.retry, ts.lateCol}, 3'b110)
    $display("transmit test done");
  endtask : testTx
  // Link fail and jabber on the twisted-pair port.
  task testTp();
    apb(1'b1, OFS_MAIN, 32'h43);
    apb(1'b1, OFS_MODE, 32'h4);
    i_mfw_net_model.cfg(1'b1, 1'b0, 1'b1, 1'b0);
    txRun(200, 1'b0);
    repeat (100) @(posedge clk);
    apb(1'b0, OFS_MAIN, 32'h0);
    `CHK({ts.carrierLost, rd[0]}, 2'b11)
    apb(1'b1, OFS_MAIN, 32'h43);
    i_mfw_net_model.cfg(1'b1, 1'b0, 1'b0, 1'b1);
    txRun(200, 1'b0);
    repeat (100) @(posedge clk);
    apb(1'b0, OFS_MAIN, 32'h0);
    `CHK({ts.carrierLost, rd[0]}, 2'b10)
    i_mfw_net_model.cfg(1'b1, 1'b1, 1'b0, 1'b0);
    apb(1'b1, OFS_MODE, 32'h0);
    $display("twisted pair test done");
  endtask : testTp
  // Pad strip, checksum, runts, receive collisions and accept-all.
  task testRx();
    pl = {};
    apb(1'b1, OFS_FEAT, 32'h400);
    build(16'h000a, 64);
    rxRun(-1, 24, 3'b100);
    fr[40] = ~fr[40];
    rxRun(-1, 24, 3'b101);
    build(16'h002e, 64);
    rxRun(-1, 64, 3'b100);
    apb(1'b1, OFS_FEAT, 32'h0);
    build(16'h0800, 40);
    rxRun(-1, -1, 3'b010);
    apb(1'b1, OFS_TEST, 32'h1);
    rxRun(-1, 40, 3'b100);
    apb(1'b1, OFS_TEST, 32'h0);
    build(16'h0800, 64);
    rxRun(5, -1, 3'b010);
    apb(1'b1, OFS_MODE, 32'h2);
    rxRun(-1, -1, 3'b010);
    apb(1'b1, OFS_MODE, 32'h3);
    rxRun(-1, 64, 3'b100);
    apb(1'b1, OFS_MODE, 32'h0);
    $display("receive test done");
  endtask : testRx
  // Wake-frame suspend by register and by pin, recognition and indication.
  task testWake();
    apb(1'b1, OFS_ADRL, 32'h44332211);
    apb(1'b1, OFS_ADRH, 32'h6655);
    apb(1'b1, OFS_PWR, 32'h2);
    apb(1'b1, OFS_PWR, 32'h6);
    waitSusp(1'b1);
    `CHK(flushSeen, 1'b1)
    wakeFrame(15);
    `CHK(wakeIndicator, 1'b0)
    wakeFrame(16);
    `CHK({wakeIndicator, interruptOutput}, 2'b10)
    apb(1'b0, OFS_PWR, 32'h0);
    `CHK(rd[5:1], 5'b11011)
    apb(1'b1, OFS_PWR, 32'h1e);
    wakeFrame(16);
    `CHK({wakeIndicator, interruptOutput}, 2'b11)
    apb(1'b1, OFS_PWR, 32'h12);
    waitSusp(1'b0);
    sleepReq_n <= 1'b0;
    waitSusp(1'b1);
    sleepReq_n <= 1'b1;
    waitSusp(1'b0);
    $display("wake test done");
  endtask : testWake
  // Main sequence: reset for 20 cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    testRegs();
    testTx();
    testTp();
    testRx();
    testWake();
    stopTest();
  end
endmodule : test_mfw_core
